// ===== design/sci_defs.svh
/*
 * Shared constants of the sensor command interface: command codes,
 * packet layout, configuration store geometry and timing counts.
 * Assumes a 40 MHz core clock and inclusion by bare name.
 */
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

`define SCI_MCLK_MHZ       40
`define SCI_T_CMD_US       10
`define SCI_T_EEPROG_US    15000
`define SCI_T_WINDOW_US    6000
`define SCI_CMD_CYC        (`SCI_T_CMD_US * `SCI_MCLK_MHZ)
`define SCI_EEPROG_CYC     (`SCI_T_EEPROG_US * `SCI_MCLK_MHZ)
`define SCI_WINDOW_CYC     (`SCI_T_WINDOW_US * `SCI_MCLK_MHZ)
`define SCI_CNT_W          20

`define SCI_EE_WORDS       20
`define SCI_SIG_WORD       5'h13
`define SCI_CID0_ADDR      5'h00
`define SCI_CID0_X_LSB     0
`define SCI_CID0_WAFER_LSB 8
`define SCI_CID0_LOT_LSB   13

`define SCI_CMD_RD_LAST    8'h13
`define SCI_CMD_WR_FIRST   8'h40
`define SCI_CMD_WR_LAST    8'h53
`define SCI_CMD_LEAVE      8'h80
`define SCI_CMD_ENTER      8'ha0
`define SCI_RESP_BYTE      8'h5a

`define SCI_STAT_VALID     2'h0
`define SCI_STAT_STALE     2'h2
`define SCI_FETCH_MIN_BITS 6'h08
`define SCI_PKT_BITS       6'h20
`define SCI_I2C_ADDR       7'h28
`define SCI_WR_BYTES       3'h3

`endif

// ===== design/sci_pkg.sv
/*
 * Types of the sensor command interface: state and operation codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sci_pkg;

  typedef enum logic [6:0] {
    SCI_I_IDLE = 7'h01,
    SCI_I_ADDR = 7'h02,
    SCI_I_AACK = 7'h04,
    SCI_I_WR   = 7'h08,
    SCI_I_WACK = 7'h10,
    SCI_I_RD   = 7'h20,
    SCI_I_RACK = 7'h40
  } sci_i2c_st_t;

  typedef enum logic [4:0] {
    SCI_OP_NONE  = 5'h01,
    SCI_OP_READ  = 5'h02,
    SCI_OP_WRITE = 5'h04,
    SCI_OP_LEAVE = 5'h08,
    SCI_OP_ENTER = 5'h10
  } sci_op_t;

  typedef enum logic [5:0] {
    SCI_H_IDLE  = 6'h01,
    SCI_H_START = 6'h02,
    SCI_H_LOW   = 6'h04,
    SCI_H_HIGH  = 6'h08,
    SCI_H_STOP  = 6'h10,
    SCI_H_END   = 6'h20
  } sci_host_st_t;

  typedef enum logic [3:0] {
    SCI_HOP_SPI_FETCH = 4'h1,
    SCI_HOP_I2C_FETCH = 4'h2,
    SCI_HOP_I2C_WRITE = 4'h4,
    SCI_HOP_I2C_MREQ  = 4'h8
  } sci_host_op_t;

endpackage

`default_nettype wire

// ===== design/sci_link_if.sv
/*
 * Serial link between host and sensor: shared clock pin, shared
 * data pin (MISO or open-drain SDA) and interrupt/select pin.
 * Resolves pin levels from the enables; undriven data floats high.
 */
`timescale 1ns/1ps
`default_nettype none

interface sci_link_if;
  logic clk_line;
  logic host_d_oe;
  logic host_ss_n;
  logic dev_d;
  logic dev_d_oe;
  logic dev_int;
  logic dev_int_oe;
  logic data_line;
  logic int_ss_line;

  // Host only ever pulls data low
  assign data_line   = dev_d_oe ? dev_d : !host_d_oe;
  assign int_ss_line = dev_int_oe ? dev_int : host_ss_n;

  modport dev (
    input  clk_line,
    input  data_line,
    input  int_ss_line,
    output dev_d,
    output dev_d_oe,
    output dev_int,
    output dev_int_oe
  );

  modport host (
    output clk_line,
    output host_d_oe,
    output host_ss_n,
    input  data_line,
    input  int_ss_line
  );
endinterface

`default_nettype wire

// ===== design/sci_dev.sv
/*
 * Sensor end of the serial link: SPI result fetch, I2C fetch and
 * command-mode writes, configuration word store and command engine.
 * Assumes the link pins are asynchronous to mclk and that a
 * measurement core supplies results with a one-cycle valid strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sci_defs.svh"

////////////////////////////////////////////////////////////////////////
// Functional notes
// - Change MISO only after falling SCLK
// - Master samples MISO on rising SCLK
// - Fetch: bridge high, bridge low, two temperature bytes
// - Temperature T[10:3] byte three, T[2:0] top byte four
// - Master masks five low bits of byte four
// - Fetch may stop after third byte
// - Writes only in command mode over I2C
// - Write packet: address, command, sixteen data bits
// - Master pads unused data with zeros
// - Master sends only defined command codes
// - Codes 00-13 read word; fetch 5A then word
// - Codes 40-53 write word at five LSBs
// - Code 80 leaves command mode
// - Leaving: rewrite signature if programmed, else short
// - Code A0 enters command mode inside power-on window
// - Raise interrupt pin when command finishes
// - Fetch after command returns 5A first
// - Store holds twenty sixteen-bit words
// - Word 0: wafer X, wafer number, lot bits
// - Status goes stale after a fetch
// - I2C mode: select pin becomes interrupt output
module sci_dev #(
  parameter logic [6:0] I2C_ADDR   = `SCI_I2C_ADDR,
  parameter int         EEPROG_CYC = `SCI_EEPROG_CYC,
  parameter int         WINDOW_CYC = `SCI_WINDOW_CYC,
  parameter logic [7:0] WAFER_X    = 8'h00,
  parameter logic [4:0] WAFER_NUM  = 5'h00,
  parameter logic [2:0] LOT_LSBS   = 3'h0
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  sci_link_if.dev          link,
  input  wire logic        i2c_mode,
  input  wire logic        meas_valid,
  input  wire logic [13:0] bridge,
  input  wire logic [10:0] temp,
  output logic             meas_req,
  output logic             cmd_mode,
  output logic             busy,
  output logic [15:0]      customer_id_word_low
);

  logic [2:0]            scl_q;
  logic [2:0]            sda_q;
  logic [2:0]            ss_q;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  i2c_start;
  logic                  i2c_stop;
  sci_pkg::sci_i2c_st_t  st;
  logic [3:0]            bit_cnt;
  logic [2:0]            byte_cnt;
  logic [7:0]            rx;
  logic [23:0]           wbuf;
  logic                  rd;
  logic                  addr_acked;
  logic                  rd_bytes;
  logic                  mack;
  logic                  i2c_oe;
  logic [31:0]           i2c_sh;
  logic                  pkt_go;
  logic                  i2c_fetch_done;
  logic [31:0]           spi_sh;
  logic [5:0]            spi_cnt;
  logic                  spi_fetch_done;
  logic                  stale;
  logic [13:0]           bridge_q;
  logic [10:0]           temp_q;
  logic [31:0]           packet;
  logic [15:0]           ee [`SCI_EE_WORDS];
  logic [15:0]           csum;
  sci_pkg::sci_op_t      op;
  sci_pkg::sci_op_t      next_op;
  logic [4:0]            ee_addr;
  logic [15:0]           ee_data;
  logic [`SCI_CNT_W-1:0] cnt;
  logic                  prog;
  logic [15:0]           rd_word;
  logic                  resp_pend;
  logic                  int_flag;
  logic [`SCI_CNT_W-1:0] win_cnt;
  logic                  window_open;

  function automatic sci_pkg::sci_op_t decode(input logic [7:0] c,
                                              input logic       cm,
                                              input logic       win);
    if (cm && c <= `SCI_CMD_RD_LAST)
      return sci_pkg::SCI_OP_READ;
    if (cm && c >= `SCI_CMD_WR_FIRST && c <= `SCI_CMD_WR_LAST)
      return sci_pkg::SCI_OP_WRITE;
    if (cm && c == `SCI_CMD_LEAVE)
      return sci_pkg::SCI_OP_LEAVE;
    if (!cm && win && c == `SCI_CMD_ENTER)
      return sci_pkg::SCI_OP_ENTER;
    return sci_pkg::SCI_OP_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  always_ff @(posedge mclk) begin
    scl_q <= {scl_q[1:0], link.clk_line};
    sda_q <= {sda_q[1:0], link.data_line};
    ss_q  <= {ss_q[1:0], link.int_ss_line};
  end

  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign i2c_start = i2c_mode & scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign i2c_stop  = i2c_mode & scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  ////////////////////////////////////////////////////////////////////
  // Fetch packet and status
  assign packet = resp_pend ? {`SCI_RESP_BYTE, rd_word, 8'h00}
                : {stale ? `SCI_STAT_STALE : `SCI_STAT_VALID,
                   bridge_q, temp_q, 5'h00};

  always_ff @(posedge mclk) begin
    if (srst) begin
      stale    <= 1'b1;
      bridge_q <= '0;
      temp_q   <= '0;
    end else if (meas_valid) begin
      stale    <= 1'b0;
      bridge_q <= bridge;
      temp_q   <= temp;
    end else if (spi_fetch_done || i2c_fetch_done) begin
      stale    <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // SPI fetch: load on select, shift after each falling clock
  always_ff @(posedge mclk) begin
    spi_fetch_done <= 1'b0;
    // Pin is the interrupt in I2C mode, so the SPI side stays idle
    if (srst || i2c_mode) begin
      spi_sh  <= '0;
      spi_cnt <= '0;
    end else if (ss_q[2] && !ss_q[1]) begin
      spi_sh  <= packet;
      spi_cnt <= '0;
    end else if (!ss_q[1] && scl_fall) begin
      spi_sh  <= {spi_sh[30:0], 1'b0};
      if (spi_cnt != `SCI_PKT_BITS)
        spi_cnt <= spi_cnt + 6'h01;
    end else if (ss_q[1] && !ss_q[2]) begin
      spi_fetch_done <= spi_cnt >= `SCI_FETCH_MIN_BITS;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // I2C slave
  always_ff @(posedge mclk) begin
    pkt_go         <= 1'b0;
    i2c_fetch_done <= 1'b0;
    meas_req       <= 1'b0;
    if (srst || !i2c_mode) begin
      st         <= sci_pkg::SCI_I_IDLE;
      bit_cnt    <= '0;
      byte_cnt   <= '0;
      rx         <= '0;
      wbuf       <= '0;
      rd         <= 1'b0;
      addr_acked <= 1'b0;
      rd_bytes   <= 1'b0;
      mack       <= 1'b0;
      i2c_oe     <= 1'b0;
      i2c_sh     <= '0;
    end else if (i2c_start) begin
      st         <= sci_pkg::SCI_I_ADDR;
      bit_cnt    <= '0;
      byte_cnt   <= '0;
      addr_acked <= 1'b0;
      rd_bytes   <= 1'b0;
      i2c_oe     <= 1'b0;
    end else if (i2c_stop) begin
      st             <= sci_pkg::SCI_I_IDLE;
      i2c_oe         <= 1'b0;
      i2c_fetch_done <= rd_bytes;
      meas_req <= addr_acked && !rd && byte_cnt == 3'h0 && !cmd_mode;
    end else begin
      unique case (st)
        sci_pkg::SCI_I_IDLE: ;
        sci_pkg::SCI_I_ADDR, sci_pkg::SCI_I_WR: begin
          if (scl_rise) begin
            rx      <= {rx[6:0], sda_q[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (st == sci_pkg::SCI_I_WR) begin
              st     <= sci_pkg::SCI_I_WACK;
              i2c_oe <= 1'b1;
              wbuf   <= {wbuf[15:0], rx};
              if (byte_cnt != 3'h7)
                byte_cnt <= byte_cnt + 3'h1;
            end else if (rx[7:1] == I2C_ADDR) begin
              st     <= sci_pkg::SCI_I_AACK;
              i2c_oe <= 1'b1;
              rd     <= rx[0];
            end else begin
              st <= sci_pkg::SCI_I_IDLE;
            end
          end
        end
        sci_pkg::SCI_I_AACK: if (scl_fall) begin
          addr_acked <= 1'b1;
          bit_cnt    <= '0;
          if (rd) begin
            st     <= sci_pkg::SCI_I_RD;
            i2c_sh <= packet;
            i2c_oe <= ~packet[31];
          end else begin
            st     <= sci_pkg::SCI_I_WR;
            i2c_oe <= 1'b0;
          end
        end
        sci_pkg::SCI_I_WACK: if (scl_fall) begin
          st      <= sci_pkg::SCI_I_WR;
          i2c_oe  <= 1'b0;
          bit_cnt <= '0;
          pkt_go  <= byte_cnt == `SCI_WR_BYTES;
        end
        sci_pkg::SCI_I_RD: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            i2c_sh <= {i2c_sh[30:0], 1'b0};
            if (bit_cnt == 4'h8) begin
              st       <= sci_pkg::SCI_I_RACK;
              i2c_oe   <= 1'b0;
              rd_bytes <= 1'b1;
            end else begin
              i2c_oe <= ~i2c_sh[30];
            end
          end
        end
        sci_pkg::SCI_I_RACK: begin
          if (scl_rise) begin
            mack <= ~sda_q[1];
          end else if (scl_fall) begin
            bit_cnt <= '0;
            st      <= mack ? sci_pkg::SCI_I_RD : sci_pkg::SCI_I_IDLE;
            i2c_oe  <= mack & ~i2c_sh[31];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power-on command window
  always_ff @(posedge mclk) begin
    if (srst)
      win_cnt <= `SCI_CNT_W'(WINDOW_CYC);
    else if (win_cnt != '0)
      win_cnt <= win_cnt - `SCI_CNT_W'(1);
  end

  assign window_open = win_cnt != '0;

  ////////////////////////////////////////////////////////////////////
  // Command engine and configuration store
  always_comb begin
    csum = '0;
    for (int i = 0; i < `SCI_EE_WORDS; i++)
      if (5'(i) != `SCI_SIG_WORD)
        csum = csum + ee[i];
  end

  assign next_op = decode(wbuf[23:16], cmd_mode, window_open);

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < `SCI_EE_WORDS; i++)
        ee[i] <= '0;
      ee[`SCI_CID0_ADDR] <= (16'(WAFER_X)   << `SCI_CID0_X_LSB)
                          | (16'(WAFER_NUM) << `SCI_CID0_WAFER_LSB)
                          | (16'(LOT_LSBS)  << `SCI_CID0_LOT_LSB);
      op        <= sci_pkg::SCI_OP_NONE;
      ee_addr   <= '0;
      ee_data   <= '0;
      cnt       <= '0;
      busy      <= 1'b0;
      cmd_mode  <= 1'b0;
      prog      <= 1'b0;
      rd_word   <= '0;
      resp_pend <= 1'b0;
      int_flag  <= 1'b0;
    end else if (pkt_go && !busy && next_op != sci_pkg::SCI_OP_NONE) begin
      op       <= next_op;
      ee_addr  <= wbuf[20:16];
      ee_data  <= wbuf[15:0];
      busy     <= 1'b1;
      int_flag <= 1'b0;
      if (next_op == sci_pkg::SCI_OP_WRITE ||
          (next_op == sci_pkg::SCI_OP_LEAVE && prog))
        cnt <= `SCI_CNT_W'(EEPROG_CYC - 1);
      else
        cnt <= `SCI_CNT_W'(`SCI_CMD_CYC - 1);
    end else if (busy && cnt != '0) begin
      cnt <= cnt - `SCI_CNT_W'(1);
    end else if (busy) begin
      busy      <= 1'b0;
      int_flag  <= 1'b1;
      resp_pend <= 1'b1;
      unique case (op)
        sci_pkg::SCI_OP_READ:  rd_word <= ee[ee_addr];
        sci_pkg::SCI_OP_WRITE: begin
          ee[ee_addr] <= ee_data;
          prog        <= 1'b1;
        end
        sci_pkg::SCI_OP_LEAVE: begin
          cmd_mode <= 1'b0;
          prog     <= 1'b0;
          if (prog)
            ee[`SCI_SIG_WORD] <= csum;
        end
        sci_pkg::SCI_OP_ENTER: cmd_mode <= 1'b1;
        default: ;
      endcase
    end else if (meas_valid) begin
      resp_pend <= 1'b0;
      if (!cmd_mode)
        int_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drivers
  assign link.dev_d      = i2c_mode ? 1'b0 : spi_sh[31];
  assign link.dev_d_oe   = i2c_mode ? i2c_oe : ~ss_q[1];
  assign link.dev_int    = int_flag;
  assign link.dev_int_oe = i2c_mode;
  assign customer_id_word_low = ee[`SCI_CID0_ADDR];

endmodule

`default_nettype wire

// ===== design/sci_host.sv
/*
 * Host end of the serial link: SPI fetch, I2C fetch, I2C command
 * writes and bare measurement requests, clocks made from mclk.
 * Assumes the sensor end shares the pins through sci_link_if.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sci_defs.svh"

module sci_host #(
  parameter logic [6:0] I2C_ADDR = `SCI_I2C_ADDR,
  parameter int         HALF_CYC = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  sci_link_if.host                   link,
  input  wire logic                  start,
  input  wire sci_pkg::sci_host_op_t op,
  input  wire logic [7:0]            cmd,
  input  wire logic [15:0]           wdata,
  input  wire logic [2:0]            nbytes,
  output logic                       busy,
  output logic                       done,
  output logic [31:0]                rdata
);

  sci_pkg::sci_host_st_t st;
  sci_pkg::sci_host_op_t op_q;
  logic [7:0]            tick;
  logic [2:0]            slot;
  logic [2:0]            last_slot;
  logic [3:0]            bidx;
  logic                  sub;
  logic                  spi;
  logic                  rdop;
  logic [31:0]           tx;
  logic [31:0]           rx;
  logic                  ack_bit;
  logic                  cur_bit;
  logic [3:0]            last_bit;

  assign spi      = op_q == sci_pkg::SCI_HOP_SPI_FETCH;
  assign rdop     = spi || op_q == sci_pkg::SCI_HOP_I2C_FETCH;
  assign ack_bit  = slot == 3'h0 || !rdop || slot == last_slot;
  assign cur_bit  = bidx == 4'h8 ? ack_bit : tx[31];
  assign last_bit = spi ? 4'h7 : 4'h8;
  assign busy     = st != sci_pkg::SCI_H_IDLE;

  ////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_ff @(posedge mclk) begin
    done <= 1'b0;
    if (srst) begin
      st             <= sci_pkg::SCI_H_IDLE;
      op_q           <= sci_pkg::SCI_HOP_I2C_MREQ;
      tick           <= '0;
      slot           <= '0;
      last_slot      <= '0;
      bidx           <= '0;
      sub            <= 1'b0;
      tx             <= '0;
      rx             <= '0;
      rdata          <= '0;
      link.clk_line  <= 1'b1;
      link.host_d_oe <= 1'b0;
      link.host_ss_n <= 1'b1;
    end else if (st != sci_pkg::SCI_H_IDLE && tick != 8'h00) begin
      tick <= tick - 8'h01;
      // Data moves in mid-low so it never changes near a clock edge
      if (st == sci_pkg::SCI_H_LOW && !spi && tick == 8'(HALF_CYC / 2))
        link.host_d_oe <= ~cur_bit;
    end else begin
      tick <= 8'(HALF_CYC - 1);
      unique case (st)
        sci_pkg::SCI_H_IDLE: if (start) begin
          op_q <= op;
          slot <= '0;
          bidx <= '0;
          sub  <= 1'b0;
          rx   <= '0;
          st   <= sci_pkg::SCI_H_START;
          if (op == sci_pkg::SCI_HOP_SPI_FETCH) begin
            link.clk_line <= 1'b0;
            last_slot     <= nbytes - 3'h1;
          end else begin
            link.host_d_oe <= 1'b1;
            if (op == sci_pkg::SCI_HOP_I2C_FETCH) begin
              tx        <= {I2C_ADDR, 1'b1, 24'hffffff};
              last_slot <= nbytes;
            end else begin
              tx        <= {I2C_ADDR, 1'b0, cmd, wdata};
              last_slot <= op == sci_pkg::SCI_HOP_I2C_WRITE ?
                           `SCI_WR_BYTES : 3'h0;
            end
          end
        end
        sci_pkg::SCI_H_START: begin
          st <= sci_pkg::SCI_H_LOW;
          if (spi)
            link.host_ss_n <= 1'b0;
          else
            link.clk_line <= 1'b0;
        end
        sci_pkg::SCI_H_LOW: begin
          st            <= sci_pkg::SCI_H_HIGH;
          link.clk_line <= 1'b1;
          if (spi || (rdop && slot != 3'h0 && bidx != 4'h8))
            rx <= {rx[30:0], link.data_line};
        end
        sci_pkg::SCI_H_HIGH: begin
          link.clk_line <= 1'b0;
          if (bidx != 4'h8)
            tx <= {tx[30:0], 1'b1};
          if (bidx == last_bit && slot == last_slot) begin
            st <= sci_pkg::SCI_H_STOP;
          end else begin
            st <= sci_pkg::SCI_H_LOW;
            if (bidx == last_bit) begin
              bidx <= '0;
              slot <= slot + 3'h1;
            end else begin
              bidx <= bidx + 4'h1;
            end
          end
        end
        sci_pkg::SCI_H_STOP: begin
          sub <= 1'b1;
          if (spi) begin
            link.host_ss_n <= 1'b1;
            st             <= sci_pkg::SCI_H_END;
          end else if (!sub) begin
            link.host_d_oe <= 1'b1;
          end else if (!link.clk_line) begin
            link.clk_line <= 1'b1;
          end else begin
            link.host_d_oe <= 1'b0;
            st             <= sci_pkg::SCI_H_END;
          end
        end
        sci_pkg::SCI_H_END: begin
          st    <= sci_pkg::SCI_H_IDLE;
          done  <= 1'b1;
          rdata <= rx;
          if (spi)
            link.clk_line <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== test/sci_link_sva.sv
/*
 * Checker on the link signals between host and sensor ends.
 * Assumes instantiation beside the link interface in the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module sci_link_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_line,
  input wire logic host_ss_n,
  input wire logic dev_d,
  input wire logic dev_d_oe,
  input wire logic dev_int,
  input wire logic dev_int_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////
  logic       clk_q;
  logic [5:0] n_rise;

  always_ff @(posedge mclk) clk_q <= clk_line;

  // Clock rises inside one SPI frame
  always_ff @(posedge mclk) begin
    if (srst || host_ss_n)
      n_rise <= 6'h00;
    else if (clk_line && !clk_q)
      n_rise <= n_rise + 6'h01;
  end

  ////////////////////////////////////////////////////////////////
  property p_spi_change_low;
    $changed(dev_d) && !dev_int_oe && !host_ss_n |-> !clk_line;
  endproperty
  a_spi_change_low: assert property (p_spi_change_low)
    else $error("miso changed while clock high");
  property p_spi_hold_high;
    $rose(clk_line) && !host_ss_n && !dev_int_oe |-> $stable(dev_d) [*3];
  endproperty
  a_spi_hold_high: assert property (p_spi_hold_high)
    else $error("miso moved after clock rise");
  property p_spi_select;
    $fell(host_ss_n) && !dev_int_oe |-> ##[1:4] dev_d_oe;
  endproperty
  a_spi_select: assert property (p_spi_select)
    else $error("miso not driven after select");
  property p_spi_release;
    $rose(host_ss_n) && !dev_int_oe |-> ##[1:4] !dev_d_oe;
  endproperty
  a_spi_release: assert property (p_spi_release)
    else $error("miso still driven after deselect");
  property p_whole_bytes;
    $rose(host_ss_n) && !dev_int_oe |-> n_rise[2:0] == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("frame not whole bytes");
  property p_i2c_low_only;
    dev_int_oe |-> !dev_d;
  endproperty
  a_i2c_low_only: assert property (p_i2c_low_only)
    else $error("sda driven high");
  property p_i2c_oe_low;
    $changed(dev_d_oe) && dev_int_oe |-> !clk_line;
  endproperty
  a_i2c_oe_low: assert property (p_i2c_oe_low)
    else $error("sda enable moved with scl high");
  property p_reset_quiet;
    $fell(srst) |-> !dev_int && !dev_d_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("pins active after reset");
endmodule

`default_nettype wire

// ===== test/sensor_command_interface_bench.sv
/*
 * Bench joining host and sensor ends: SPI fetch, command mode.
 * Assumes the design files and the link interface are compiled.
 */
`timescale 1ns/1ps
`default_nettype none

module sensor_command_interface_bench;
  logic        mclk = 0, srst = 1, i2c_mode = 0, meas_valid = 0;
  logic        start = 0, busy, done, cmd_mode, dbusy, mreq;
  logic [13:0] bridge = '0;
  logic [10:0] temp = '0;
  logic [7:0]  cmd = '0;
  logic [15:0] wdata = '0, cid;
  logic [2:0]  nbytes = '0;
  logic [31:0] rdata;
  logic [63:0] ent, q[$];
  int          n_mismatch = 0, n_compared = 0, n_mreq = 0;
  sci_pkg::sci_host_op_t op = sci_pkg::SCI_HOP_SPI_FETCH;

  sci_link_if link();
  sci_dev #(.EEPROG_CYC(800), .WINDOW_CYC(4000), .WAFER_X(8'h3c),
    .WAFER_NUM(5'h15), .LOT_LSBS(3'h5)) i_sci_dev (.mclk(mclk),
    .srst(srst), .link(link.dev), .i2c_mode(i2c_mode),
    .meas_valid(meas_valid), .bridge(bridge), .temp(temp),
    .meas_req(mreq), .cmd_mode(cmd_mode), .busy(dbusy),
    .customer_id_word_low(cid));
  sci_host i_sci_host (.mclk(mclk), .srst(srst), .link(link.host),
    .start(start), .op(op), .cmd(cmd), .wdata(wdata), .nbytes(nbytes),
    .busy(busy), .done(done), .rdata(rdata));
  sci_link_sva i_sci_link_sva (.mclk(mclk), .srst(srst),
    .clk_line(link.clk_line), .host_ss_n(link.host_ss_n),
    .dev_d(link.dev_d), .dev_d_oe(link.dev_d_oe),
    .dev_int(link.dev_int), .dev_int_oe(link.dev_int_oe));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (e !== s) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Expected fetch words, masked, one note per host operation
  task automatic xfer(sci_pkg::sci_host_op_t o, logic [7:0] c,
                      logic [15:0] d, logic [2:0] n,
                      logic [31:0] e, logic [31:0] m);
    int k;
    q.push_back({m, e});
    @(negedge mclk);
    op = o;
    cmd = c;
    wdata = d;
    nbytes = n;
    start = 1;
    @(negedge mclk);
    start = 0;
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge mclk);
  endtask

  task automatic wait_int;
    int k;
    for (k = 0; k < 2000 && link.int_ss_line !== 1'b1; k++)
      @(negedge mclk);
    chk("interrupt", 32'h1, {31'h0, link.int_ss_line});
  endtask

  always @(negedge mclk) begin
    if (mreq === 1'b1)
      n_mreq++;
    if (done === 1'b1 && q.size() > 0) begin
      ent = q.pop_front();
      chk("rdata", ent[31:0], rdata & ent[63:32]);
    end
  end

  initial begin
    #(25 * 20000);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    logic [15:0] wd;
    void'($urandom(32'he354));
    repeat (12) @(negedge mclk);
    srst = 0;
    bridge = 14'($urandom);
    temp = 11'($urandom);
    meas_valid = 1;
    @(negedge mclk);
    meas_valid = 0;
    xfer(sci_pkg::SCI_HOP_SPI_FETCH, 8'h00, 16'h0000, 3'h4,
         {2'b00, bridge, temp, 5'h00}, 32'hffffffe0);
    xfer(sci_pkg::SCI_HOP_SPI_FETCH, 8'h00, 16'h0000, 3'h3,
         {10'h2, bridge, temp[10:3]}, 32'h00ffffff);
    i2c_mode = 1;
    xfer(sci_pkg::SCI_HOP_I2C_WRITE, 8'ha0, 16'h0, 3'h0, 0, '1);
    wait_int;
    chk("cmd_mode", 32'h1, {31'h0, cmd_mode});
    xfer(sci_pkg::SCI_HOP_I2C_WRITE, 8'h00, 16'h0, 3'h0, 0, '1);
    wait_int;
    xfer(sci_pkg::SCI_HOP_I2C_FETCH, 8'h00, 16'h0, 3'h3,
         32'h5ab53c, 32'h00ffffff);
    wd = 16'($urandom);
    xfer(sci_pkg::SCI_HOP_I2C_WRITE, 8'h40, wd, 3'h0, 0, '1);
    chk("busy", 32'h1, {31'h0, dbusy});
    wait_int;
    chk("word0", {16'h0, wd}, {16'h0, cid});
    xfer(sci_pkg::SCI_HOP_I2C_WRITE, 8'h13, 16'h0, 3'h0, 0, '1);
    wait_int;
    xfer(sci_pkg::SCI_HOP_I2C_FETCH, 8'h00, 16'h0, 3'h3,
         32'h5a0000, 32'h00ffffff);
    xfer(sci_pkg::SCI_HOP_I2C_WRITE, 8'h80, 16'h0, 3'h0, 0, '1);
    // Programmed store: leaving takes the long signature rewrite
    repeat (500) @(negedge mclk);
    chk("busy", 32'h1, {31'h0, dbusy});
    wait_int;
    chk("cmd_mode", 32'h0, {31'h0, cmd_mode});
    xfer(sci_pkg::SCI_HOP_I2C_MREQ, 8'h00, 16'h0, 3'h0, 0, '1);
    chk("meas_req", 32'h1, n_mreq);
    wrap_up;
  end
endmodule

`default_nettype wire
